// >>> hw/mft_map.svh
// Register offsets, field positions, reset values and bases of the multifunction timer
`ifndef MFT_MAP_SVH
`define MFT_MAP_SVH

`define MFT_BASE_ONE        32'h40d00000
`define MFT_BASE_TWO        32'h40e00000
`define MFT_OFF_CNT1        8'h00
`define MFT_OFF_CRA         8'h04
`define MFT_OFF_CRB         8'h08
`define MFT_OFF_CNT2        8'h0c
`define MFT_OFF_PRSC        8'h10
`define MFT_OFF_CKC         8'h14
`define MFT_OFF_MCTRL       8'h18
`define MFT_OFF_ICTRL       8'h1c
`define MFT_OFF_ICLR        8'h20
`define MFT_MC_MODE_LSB     0
`define MFT_MC_AEN_BIT      3
`define MFT_MC_BEN_BIT      4
`define MFT_MC_AOUT_BIT     5
`define MFT_MC_AEDG_BIT     6
`define MFT_MC_BEDG_BIT     7
`define MFT_MC_PTSE_BIT     8
`define MFT_MC_EN_BIT       9
`define MFT_CKC_C2_LSB      3
`define MFT_IC_PEND_LSB     4
`define MFT_PRESET          16'hffff
`define MFT_CTRL_RESET      8'h00

`endif

// >>> hw/mft_pkg.sv
// Types shared by the multifunction timer
`default_nettype none
package mft_pkg;
  typedef enum logic [2:0] {
    MODE_ONE     = 3'b000,
    MODE_TWO     = 3'b001,
    MODE_THREE   = 3'b010,
    MODE_FOUR    = 3'b011,
    MODE_ONE_PT  = 3'b100
  } mode_t;
  typedef enum logic [2:0] {
    CLK_NONE     = 3'b000,
    CLK_PRESCALE = 3'b001,
    CLK_EVENT    = 3'b010,
    CLK_ACCUM    = 3'b011
  } clk_sel_t;
endpackage
`default_nettype wire

// >>> hw/pin_edge_detect.sv
// Pin synchroniser with selectable edge detection
`default_nettype none
module pin_edge_detect (
  input  wire logic ref_clk_in,
  input  wire logic nrst_in,
  input  wire logic clk_en_in,
  input  wire logic pin_in,
  input  wire logic rise_sel_in,
  output logic      level_out,
  output logic      edge_out
);
  logic meta;
  logic sync;
  logic prev;

  // Two stages before any logic looks at the pin
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else if (clk_en_in)
    begin
      meta <= pin_in;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_out = sync;
  assign edge_out  = rise_sel_in ? (sync & ~prev) : (~sync & prev);
endmodule // pin_edge_detect
`default_nettype wire

// >>> hw/mft_timer.sv
// Dual-instance multifunction timer with APB register access
//
// Contract
// - Modes 1,1a,3,4 with pin-A enable: pin A toggles on counter one underflow.
// - Mode 2: pin A edge captures counter one to A; preset if enabled.
// - Mode 2, pin-B enable clear: pin B edge captures counter one to B.
// - Mode 4: pin B edge captures counter two to B; preset if enabled.
// - Modes 1 and 3: pin B is event or accumulate clock input.
// - Mode 1a: pin B is event input only while pulse-train start is zero.
// - A capture counter holds until its first input event.
// - Instance one drives waveform line zero, instance two line one.
// - Each instance has sources A to D on two interrupt lines.
// - Each source sets its pending flag; each flag has a software enable.
// - A, B, C drive line a; D drives line b.
// - Flag A: reload from A in modes 1,1a,3,4; pin A capture in 2.
// - Flag B: reload from B in 1,1a; pin B capture in 2,4; never 3.
// - Flag C: only mode 2, on counter one underflow.
// - Flag D: counter two underflow; in mode 3 its reload from B.
// - Two identical maps at the two base addresses.
// - Counter one sits in bits 15:0, not reset, reads live.
// - Capture A keeps content through reset; writes only when enabled.
// - Pin A waveform level starts at and reads as the output-level bit.
// - On underflow counter one reloads: A in modes 3,4, A and B in turn in 1,1a, 0xffff in 2; keeps counting.
// - Mode 4 preset: capture to B first, then load counter two 0xffff.
`include "mft_map.svh"
`default_nettype none
module mft_timer #(
  parameter logic [31:0] BASE_ONE = `MFT_BASE_ONE,
  parameter logic [31:0] BASE_TWO = `MFT_BASE_TWO
) (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        clk_en_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [1:0]  timer_pin_first_in,
  input  wire logic [1:0]  timer_pin_second_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             waveform_line_zero_out,
  output logic             waveform_line_one_out,
  output logic [1:0]       pin_first_oe_out,
  output logic             instance_one_irq_line_a_out,
  output logic             instance_one_irq_line_b_out,
  output logic             instance_two_irq_line_a_out,
  output logic             instance_two_irq_line_b_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic mft_pkg::mode_t to_mode(input logic [2:0] raw);
    case (raw)
      3'b001:  to_mode = mft_pkg::MODE_TWO;
      3'b010:  to_mode = mft_pkg::MODE_THREE;
      3'b011:  to_mode = mft_pkg::MODE_FOUR;
      3'b100:  to_mode = mft_pkg::MODE_ONE_PT;
      default: to_mode = mft_pkg::MODE_ONE;
    endcase
  endfunction

  // Counter clock from its select; external sources except where pin B captures that counter or mode 1a has pulse-train start set
  function automatic logic clk_tick(input logic [2:0] sel, input logic ptick,
                                    input logic bedge, input logic blvl,
                                    input logic ext_ok);
    case (sel)
      mft_pkg::CLK_PRESCALE: clk_tick = ptick;
      mft_pkg::CLK_EVENT:    clk_tick = ext_ok & bedge;
      mft_pkg::CLK_ACCUM:    clk_tick = ext_ok & blvl & ptick;
      default:               clk_tick = 1'b0;
    endcase
  endfunction

  function automatic logic offset_ok(input logic [7:0] off);
    offset_ok = (off[1:0] == 2'b00) && (off <= `MFT_OFF_ICLR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  mft_pkg::mode_t mode       [2];
  logic           en_a       [2];
  logic           en_b       [2];
  logic           out_lvl    [2];
  logic           edg_a      [2];
  logic           edg_b      [2];
  logic           pts        [2];
  logic           gen        [2];
  logic [7:0]     prsc       [2];
  logic [7:0]     pcnt       [2];
  logic [2:0]     csel1      [2];
  logic [2:0]     csel2      [2];
  logic [3:0]     ien        [2];
  logic [3:0]     pend       [2];
  logic [15:0]    cnt1       [2];
  logic [15:0]    cnt2       [2];
  logic [15:0]    cra        [2];
  logic [15:0]    crb        [2];
  logic           next_src_b [2];
  logic           wait1      [2];
  logic           wait2      [2];
  logic           irq_a      [2];
  logic           irq_b      [2];
  logic           oe         [2];
  logic [31:0]    rd_word    [2];

  logic           acc_inst;
  logic [7:0]     acc_off;
  logic           wr_go;
  logic           hit_one;
  logic           hit_two;
  logic [7:0]     req_off;

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait state, answer registered in the setup cycle

  assign hit_one = (paddr_in[31:8] == BASE_ONE[31:8]);
  assign hit_two = (paddr_in[31:8] == BASE_TWO[31:8]);
  assign req_off = paddr_in[7:0];
  assign wr_go   = pready_out & psel_in & penable_in & pwrite_in & ~pslverr_out;

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
      acc_inst    <= 1'b0;
      acc_off     <= 8'h00;
    end
    else if (clk_en_in)
    begin
      if (psel_in && !penable_in && !pready_out)
      begin
        pready_out  <= 1'b1;
        acc_inst    <= hit_two;
        acc_off     <= req_off;
        pslverr_out <= !((hit_one || hit_two) && offset_ok(req_off));
        if (!pwrite_in && (hit_one || hit_two) && offset_ok(req_off))
          prdata_out <= rd_word[hit_two];
        else
          prdata_out <= 32'h00000000;
      end
      else
      begin
        pready_out  <= 1'b0;
        pslverr_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-instance timers

  logic [1:0] a_edge;
  logic [1:0] b_edge;
  logic [1:0] b_lvl;

  for (genvar i = 0; i < 2; i++)
  begin : g_inst
    logic wsel;
    logic w_cnt1, w_cra, w_crb, w_cnt2, w_prsc, w_ckc, w_mc, w_ic, w_clr;
    logic ptick, tick1, tick2, uf1, uf2, cap_a, cap_b, m2, m4, m1x;
    logic ext1, ext2, run1, run2;
    logic [3:0] set;

    pin_edge_detect u_pin_a (
      .ref_clk_in  (ref_clk_in),
      .nrst_in     (nrst_in),
      .clk_en_in   (clk_en_in),
      .pin_in      (timer_pin_first_in[i]),
      .rise_sel_in (edg_a[i]),
      .level_out   (),
      .edge_out    (a_edge[i])
    );

    // A pin B pulse shorter than a clock may be missed
    pin_edge_detect u_pin_b (
      .ref_clk_in  (ref_clk_in),
      .nrst_in     (nrst_in),
      .clk_en_in   (clk_en_in),
      .pin_in      (timer_pin_second_in[i]),
      .rise_sel_in (edg_b[i]),
      .level_out   (b_lvl[i]),
      .edge_out    (b_edge[i])
    );

    assign wsel   = wr_go & (acc_inst == 1'(i));
    assign w_cnt1 = wsel & (acc_off == `MFT_OFF_CNT1);
    assign w_cra  = wsel & (acc_off == `MFT_OFF_CRA) & gen[i];
    assign w_crb  = wsel & (acc_off == `MFT_OFF_CRB) & gen[i];
    assign w_cnt2 = wsel & (acc_off == `MFT_OFF_CNT2);
    assign w_prsc = wsel & (acc_off == `MFT_OFF_PRSC);
    assign w_ckc  = wsel & (acc_off == `MFT_OFF_CKC);
    assign w_mc   = wsel & (acc_off == `MFT_OFF_MCTRL);
    assign w_ic   = wsel & (acc_off == `MFT_OFF_ICTRL);
    assign w_clr  = wsel & (acc_off == `MFT_OFF_ICLR);

    assign m2  = (mode[i] == mft_pkg::MODE_TWO);
    assign m4  = (mode[i] == mft_pkg::MODE_FOUR);
    assign m1x = (mode[i] == mft_pkg::MODE_ONE) || (mode[i] == mft_pkg::MODE_ONE_PT);
    assign ext1 = (mode[i] == mft_pkg::MODE_ONE) || (mode[i] == mft_pkg::MODE_THREE)
                  || m4 || ((mode[i] == mft_pkg::MODE_ONE_PT) && !pts[i]);
    assign ext2 = (mode[i] == mft_pkg::MODE_ONE) || (mode[i] == mft_pkg::MODE_THREE)
                  || m2 || ((mode[i] == mft_pkg::MODE_ONE_PT) && !pts[i]);

    assign ptick = gen[i] & (pcnt[i] == 8'h00);
    assign tick1 = clk_tick(csel1[i], ptick, b_edge[i], b_lvl[i], ext1);
    assign tick2 = clk_tick(csel2[i], ptick, b_edge[i], b_lvl[i], ext2);
    assign run1  = gen[i] & tick1 & !(m2 & wait1[i]);
    assign run2  = gen[i] & tick2 & !(m4 & wait2[i]);
    assign uf1   = run1 & (cnt1[i] == 16'h0000);
    assign uf2   = run2 & (cnt2[i] == 16'h0000);
    assign cap_a = gen[i] & m2 & a_edge[i];
    assign cap_b = gen[i] & (m2 | m4) & b_edge[i];

    assign set[0] = (uf1 & !m2 & !(m1x & next_src_b[i])) | cap_a;
    assign set[1] = (uf1 & m1x & next_src_b[i]) | cap_b;
    assign set[2] = uf1 & m2;
    assign set[3] = uf2;

    // Prescaler reloads at its own underflow and while the timer is disabled
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
      if (!nrst_in)
        pcnt[i] <= 8'h00;
      else if (clk_en_in)
      begin
        if (!gen[i] || pcnt[i] == 8'h00)
          pcnt[i] <= prsc[i];
        else
          pcnt[i] <= pcnt[i] - 8'h01;
      end
    end

    // Control registers
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        mode[i]  <= mft_pkg::MODE_ONE;
        en_a[i]  <= 1'b0;
        en_b[i]  <= 1'b0;
        edg_a[i] <= 1'b0;
        edg_b[i] <= 1'b0;
        pts[i]   <= 1'b0;
        gen[i]   <= 1'b0;
        prsc[i]  <= `MFT_CTRL_RESET;
        csel1[i] <= 3'h0;
        csel2[i] <= 3'h0;
        ien[i]   <= 4'h0;
      end
      else if (clk_en_in)
      begin
        if (w_mc)
        begin
          mode[i]  <= to_mode(pwdata_in[`MFT_MC_MODE_LSB +: 3]);
          en_a[i]  <= pwdata_in[`MFT_MC_AEN_BIT];
          en_b[i]  <= pwdata_in[`MFT_MC_BEN_BIT];
          edg_a[i] <= pwdata_in[`MFT_MC_AEDG_BIT];
          edg_b[i] <= pwdata_in[`MFT_MC_BEDG_BIT];
          pts[i]   <= pwdata_in[`MFT_MC_PTSE_BIT];
          gen[i]   <= pwdata_in[`MFT_MC_EN_BIT];
        end
        if (w_prsc)
          prsc[i] <= pwdata_in[7:0];
        if (w_ckc)
        begin
          csel1[i] <= pwdata_in[2:0];
          csel2[i] <= pwdata_in[`MFT_CKC_C2_LSB +: 3];
        end
        if (w_ic)
          ien[i] <= pwdata_in[3:0];
      end
    end

    // Pending flags: a new event beats a clear in the same cycle
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
      if (!nrst_in)
        pend[i] <= 4'h0;
      else if (clk_en_in)
        pend[i] <= (pend[i] & ~({4{w_clr}} & pwdata_in[3:0])) | set;
    end

    // Hold flags for capture modes, rearmed while disabled
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        wait1[i] <= 1'b1;
        wait2[i] <= 1'b1;
      end
      else if (clk_en_in)
      begin
        if (!gen[i])
        begin
          wait1[i] <= 1'b1;
          wait2[i] <= 1'b1;
        end
        else
        begin
          if (cap_a || (m2 && cap_b))
            wait1[i] <= 1'b0;
          if (m4 && cap_b)
            wait2[i] <= 1'b0;
        end
      end
    end

    // Pin A level, alternate reload source, output enable, interrupt lines
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        out_lvl[i]    <= 1'b0;
        next_src_b[i] <= 1'b0;
        oe[i]         <= 1'b0;
        irq_a[i]      <= 1'b0;
        irq_b[i]      <= 1'b0;
      end
      else if (clk_en_in)
      begin
        if (w_mc)
          out_lvl[i] <= pwdata_in[`MFT_MC_AOUT_BIT];
        else if (uf1 && en_a[i] && !m2)
          out_lvl[i] <= ~out_lvl[i];
        if (!m1x || !gen[i])
          next_src_b[i] <= 1'b0;
        else if (uf1)
          next_src_b[i] <= ~next_src_b[i];
        oe[i]    <= en_a[i] & !m2;
        irq_a[i] <= |(pend[i][2:0] & ien[i][2:0]);
        irq_b[i] <= pend[i][3] & ien[i][3];
      end
    end

    // Counters and capture registers keep their content through reset
    always_ff @(posedge ref_clk_in)
    begin
      if (clk_en_in)
      begin
        if (cap_a && en_a[i])
          cnt1[i] <= `MFT_PRESET;
        else if (m2 && cap_b && en_b[i])
          cnt1[i] <= `MFT_PRESET;
        else if (w_cnt1)
          cnt1[i] <= pwdata_in[15:0];
        else if (uf1)
        begin
          if (m2)
            cnt1[i] <= `MFT_PRESET;
          else if (m1x && next_src_b[i])
            cnt1[i] <= crb[i];
          else
            cnt1[i] <= cra[i];
        end
        else if (run1)
          cnt1[i] <= cnt1[i] - 16'h0001;
      end
    end

    always_ff @(posedge ref_clk_in)
    begin
      if (clk_en_in)
      begin
        if (cap_a || (m2 && cap_b && en_b[i]))
          cra[i] <= cnt1[i];
        else if (w_cra)
          cra[i] <= pwdata_in[15:0];
      end
    end

    always_ff @(posedge ref_clk_in)
    begin
      if (clk_en_in)
      begin
        if (m2 && cap_b && !en_b[i])
          crb[i] <= cnt1[i];
        else if (m4 && cap_b)
          crb[i] <= cnt2[i];
        else if (w_crb)
          crb[i] <= pwdata_in[15:0];
      end
    end

    // Preset sees the pre-edge count already copied into capture B
    always_ff @(posedge ref_clk_in)
    begin
      if (clk_en_in)
      begin
        if (m4 && cap_b && en_b[i])
          cnt2[i] <= `MFT_PRESET;
        else if (w_cnt2)
          cnt2[i] <= pwdata_in[15:0];
        else if (uf2)
          cnt2[i] <= (mode[i] == mft_pkg::MODE_THREE) ? crb[i] : `MFT_PRESET;
        else if (run2)
          cnt2[i] <= cnt2[i] - 16'h0001;
      end
    end

    // Read view of this instance
    always_comb
    begin
      rd_word[i] = 32'h00000000;
      if (req_off == `MFT_OFF_CNT1)
        rd_word[i] = {16'h0000, cnt1[i]};
      else if (req_off == `MFT_OFF_CRA)
        rd_word[i] = {16'h0000, cra[i]};
      else if (req_off == `MFT_OFF_CRB)
        rd_word[i] = {16'h0000, crb[i]};
      else if (req_off == `MFT_OFF_CNT2)
        rd_word[i] = {16'h0000, cnt2[i]};
      else if (req_off == `MFT_OFF_PRSC)
        rd_word[i] = {24'h000000, prsc[i]};
      else if (req_off == `MFT_OFF_CKC)
        rd_word[i] = {26'h0000000, csel2[i], csel1[i]};
      else if (req_off == `MFT_OFF_MCTRL)
        rd_word[i] = {22'h000000, gen[i], pts[i], edg_b[i], edg_a[i], out_lvl[i], en_b[i],
                      en_a[i], mode[i]};
      else if (req_off == `MFT_OFF_ICTRL)
        rd_word[i] = {24'h000000, pend[i], ien[i]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign waveform_line_zero_out      = out_lvl[0];
  assign waveform_line_one_out       = out_lvl[1];
  assign pin_first_oe_out            = {oe[1], oe[0]};
  assign instance_one_irq_line_a_out = irq_a[0];
  assign instance_one_irq_line_b_out = irq_b[0];
  assign instance_two_irq_line_a_out = irq_a[1];
  assign instance_two_irq_line_b_out = irq_b[1];

endmodule // mft_timer
`default_nettype wire

// >>> dv/mft_timer_asserts.sv
// Concurrent checks on the timer bus, pin-A output and interrupt lines
`include "mft_map.svh"
`default_nettype none
module mft_timer_asserts #(
  parameter logic [31:0] BASE_ONE = `MFT_BASE_ONE,
  parameter logic [31:0] BASE_TWO = `MFT_BASE_TWO
) (
  input wire logic        ref_clk_in,
  input wire logic        nrst_in,
  input wire logic        clk_en_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        waveform_line_zero_out,
  input wire logic        waveform_line_one_out,
  input wire logic [1:0]  pin_first_oe_out,
  input wire logic        instance_one_irq_line_a_out,
  input wire logic        instance_one_irq_line_b_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////
  logic [31:0] mc_d;
  wire logic pg1 = paddr_in[31:8] == BASE_ONE[31:8];
  wire logic pg2 = paddr_in[31:8] == BASE_TWO[31:8];
  wire logic hit = (pg1 || pg2) && paddr_in[7:0] <= 8'h20 && paddr_in[1:0] == 2'b00;
  wire logic wr = psel_in && penable_in && pwrite_in && pready_out;
  wire logic mc1 = wr && pg1 && paddr_in[7:0] == `MFT_OFF_MCTRL;
  wire logic mc2 = wr && pg2 && paddr_in[7:0] == `MFT_OFF_MCTRL;
  wire logic ic1 = wr && pg1 && paddr_in[7:0] == `MFT_OFF_ICTRL;
  wire logic lvl = pwdata_in[5] && pwdata_in[3] && pwdata_in[2:0] != 3'b001;
  // Keeps the control word: the bus drops it before the enable settles
  always_ff @(posedge ref_clk_in)
  begin
    if (mc1)
      mc_d <= pwdata_in;
  end
  ////////////////////////////////////////
  property p_rdy;
    psel_in && !penable_in && clk_en_in |=> pready_out;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready missing after setup");
  property p_pulse;
    pready_out |=> !pready_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_err;
    pready_out && !hit |-> pslverr_out;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_noerr;
    pready_out && hit |-> !pslverr_out;
  endproperty
  a_noerr: assert property (p_noerr) else $error("mapped access refused");
  property p_oe;
    mc1 |=> ##1 pin_first_oe_out[0] == (mc_d[3] && mc_d[2:0] != 3'b001);
  endproperty
  a_oe: assert property (p_oe) else $error("pin A drive enable wrong");
  property p_wave0;
    mc1 && lvl |-> ##[1:2] waveform_line_zero_out;
  endproperty
  a_wave0: assert property (p_wave0) else $error("line zero level wrong");
  property p_wave1;
    mc2 && lvl |-> ##[1:2] waveform_line_one_out;
  endproperty
  a_wave1: assert property (p_wave1) else $error("line one level wrong");
  property p_irq_off;
    ic1 && pwdata_in[3:0] == 4'h0 |=> ##1 !instance_one_irq_line_a_out
      && !instance_one_irq_line_b_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq line with no enable");
  c_err: cover property (pslverr_out);
  c_mc2: cover property (mc2 && lvl);
  c_irq: cover property (instance_one_irq_line_b_out);
endmodule // mft_timer_asserts
bind mft_timer mft_timer_asserts #(.BASE_ONE(BASE_ONE), .BASE_TWO(BASE_TWO)) chk_u (
  .ref_clk_in, .nrst_in, .clk_en_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .pready_out, .pslverr_out, .waveform_line_zero_out, .waveform_line_one_out,
  .pin_first_oe_out, .instance_one_irq_line_a_out, .instance_one_irq_line_b_out
);
`default_nettype wire

// >>> dv/pin_source.sv
// External pin drivers feeding both timer instances
`default_nettype none
module pin_source (
  input  wire logic       ref_clk_in,
  input  wire logic [1:0] pin_first_oe_in,
  output logic [1:0]      pin_first_out,
  output logic [1:0]      pin_second_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    pin_first_out = 2'b00;
    pin_second_out = 2'b00;
  end
  // Pin A is left alone while the device drives it
  task automatic pulse(input logic on_b, input int k);
    @(posedge ref_clk_in);
    if (on_b)
      pin_second_out[k] <= 1'b1;
    else if (!pin_first_oe_in[k])
      pin_first_out[k] <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    pin_first_out[k] <= 1'b0;
    pin_second_out[k] <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
  endtask
endmodule // pin_source
`default_nettype wire

// >>> dv/tb_mft_timer.sv
// Self-checking bench for the dual multifunction timer
`include "mft_map.svh"
`default_nettype none
module tb_mft_timer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] B1 = `MFT_BASE_ONE;
  localparam logic [31:0] B2 = `MFT_BASE_TWO;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [31:0] padr = 32'h0;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic [31:0] rdat;
  logic        rdy;
  logic        serr;
  logic        rerr;
  logic [1:0]  pa;
  logic [1:0]  pb;
  logic [1:0]  oe;
  logic [5:0]  obs;
  int          err_count = 0;
  int          cmp_count = 0;
  always #5 clk = ~clk;
  ////////////////////////////////////////
  mft_timer dut_u (
    .ref_clk_in(clk), .nrst_in(nrst), .clk_en_in(1'b1), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .timer_pin_first_in(pa),
    .timer_pin_second_in(pb), .prdata_out(prd), .pready_out(rdy), .pslverr_out(serr),
    .waveform_line_zero_out(obs[4]), .waveform_line_one_out(obs[5]),
    .pin_first_oe_out(oe), .instance_one_irq_line_a_out(obs[0]),
    .instance_one_irq_line_b_out(obs[1]), .instance_two_irq_line_a_out(obs[2]),
    .instance_two_irq_line_b_out(obs[3])
  );
  pin_source pins_u (.ref_clk_in(clk), .pin_first_oe_in(oe), .pin_first_out(pa),
    .pin_second_out(pb));
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("Counts: %0d mismatches in %0d comparisons", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Waits an edge first so a new setup never lands in the release step
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'b1 && n < 20);
    rdat = prd;
    rerr = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (rdy !== 1'b1)
    begin
      chk("pready", 32'h1, 32'h0);
      give_verdict();
    end
  endtask
  task automatic wr(input logic [31:0] b, input logic [7:0] o, input logic [31:0] d);
    apb(1'b1, b | {24'h0, o}, d);
  endtask
  task automatic rd(input logic [31:0] b, input logic [7:0] o);
    apb(1'b0, b | {24'h0, o}, 32'h0);
  endtask
  task automatic wait_obs(input string nm, input int k, input logic v);
    int n;
    n = 0;
    while (obs[k] !== v && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    chk(nm, 32'(v), 32'(obs[k]));
    if (obs[k] !== v)
      give_verdict();
  endtask
  ////////////////////////////////////////
  task automatic s_regs();
    logic [7:0] offs [5];
    offs = '{`MFT_OFF_PRSC, `MFT_OFF_CKC, `MFT_OFF_MCTRL, `MFT_OFF_ICTRL, `MFT_OFF_ICLR};
    foreach (offs[i])
    begin
      rd(B1, offs[i]);
      chk("reset one", 32'h0, rdat);
      rd(B2, offs[i]);
      chk("reset two", 32'h0, rdat);
    end
    rd(B1, 8'h24);
    chk("err gap", 32'h1, 32'(rerr));
    rd(32'h40f00000, 8'h00);
    chk("err page", 32'h1, 32'(rerr));
    rd(B2, 8'h06);
    chk("err align", 32'h1, 32'(rerr));
  endtask
  task automatic s_hold();
    wr(B1, `MFT_OFF_MCTRL, 32'h200);
    wr(B1, `MFT_OFF_CRA, 32'h1234);
    wr(B1, `MFT_OFF_CNT1, 32'h0777);
    wr(B1, `MFT_OFF_MCTRL, 32'h0);
    wr(B1, `MFT_OFF_CRA, 32'h5678);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(B1, `MFT_OFF_CRA);
    chk("cap a", 32'h1234, 32'(rdat[15:0]));
    rd(B1, `MFT_OFF_CNT1);
    chk("cnt one", 32'h0777, 32'(rdat[15:0]));
  endtask
  task automatic s_mode1();
    wr(B1, `MFT_OFF_MCTRL, 32'h228);
    wait_obs("wave zero", 4, 1'b1);
    wr(B1, `MFT_OFF_CRA, 32'h4);
    wr(B1, `MFT_OFF_CRB, 32'h4);
    wr(B1, `MFT_OFF_CNT1, 32'h10);
    wr(B1, `MFT_OFF_CNT2, 32'h3);
    wr(B1, `MFT_OFF_CKC, 32'h9);
    rd(B1, `MFT_OFF_CNT1);
    chk("cnt one live", 32'h1, 32'(rdat[15:0] < 16'h0010));
    wait_obs("wave zero", 4, 1'b0);
    wait_obs("wave zero", 4, 1'b1);
    rd(B1, `MFT_OFF_ICTRL);
    chk("flags", 32'hb, 32'(rdat[7:4]));
    wr(B1, `MFT_OFF_ICTRL, 32'h8);
    wait_obs("irq one b", 1, 1'b1);
    chk("irq one a", 32'h0, 32'(obs[0]));
    wr(B1, `MFT_OFF_CKC, 32'h0);
    wr(B1, `MFT_OFF_ICLR, 32'h0);
    rd(B1, `MFT_OFF_ICTRL);
    chk("flags kept", 32'hb, 32'(rdat[7:4]));
    wr(B1, `MFT_OFF_ICLR, 32'hf);
    rd(B1, `MFT_OFF_ICTRL);
    chk("flags clear", 32'h0, 32'(rdat[7:4]));
    wait_obs("irq one b", 1, 1'b0);
    wr(B1, `MFT_OFF_ICTRL, 32'h0);
  endtask
  task automatic s_mode2();
    wr(B1, `MFT_OFF_MCTRL, 32'h2c1);
    wr(B1, `MFT_OFF_CNT1, 32'h42);
    wr(B1, `MFT_OFF_CKC, 32'h1);
    rd(B1, `MFT_OFF_CNT1);
    chk("cnt one held", 32'h42, 32'(rdat[15:0]));
    pins_u.pulse(1'b1, 0);
    rd(B1, `MFT_OFF_CRB);
    chk("cap b", 32'h42, 32'(rdat[15:0]));
    pins_u.pulse(1'b0, 0);
    rd(B1, `MFT_OFF_CRA);
    chk("cap a moved", 32'h1, 32'(rdat[15:0] < 16'h0042));
    rd(B1, `MFT_OFF_ICTRL);
    chk("flags", 32'h3, 32'(rdat[7:4]));
  endtask
  task automatic s_mode3();
    wr(B1, `MFT_OFF_MCTRL, 32'h282);
    wr(B1, `MFT_OFF_CKC, 32'ha);
    wr(B1, `MFT_OFF_ICLR, 32'hf);
    wr(B1, `MFT_OFF_CRB, 32'h5);
    wr(B1, `MFT_OFF_CNT1, 32'h9);
    wr(B1, `MFT_OFF_CNT2, 32'h0);
    pins_u.pulse(1'b1, 0);
    rd(B1, `MFT_OFF_CNT1);
    chk("event count", 32'h8, 32'(rdat[15:0]));
    rd(B1, `MFT_OFF_CNT2);
    chk("reload b", 32'h1, 32'(rdat[15:0] < 16'h0006));
    rd(B1, `MFT_OFF_ICTRL);
    chk("flags three", 32'h8, 32'(rdat[7:4]));
  endtask
  task automatic s_mode4();
    wr(B2, `MFT_OFF_MCTRL, 32'h2bb);
    wait_obs("wave one", 5, 1'b1);
    wr(B2, `MFT_OFF_CNT2, 32'h1000);
    wr(B2, `MFT_OFF_CKC, 32'h8);
    pins_u.pulse(1'b1, 1);
    rd(B2, `MFT_OFF_CRB);
    chk("cap b two", 32'h1000, 32'(rdat[15:0]));
    rd(B2, `MFT_OFF_CNT2);
    chk("preset", 32'h1, 32'(rdat[15:0] > 16'hff00));
    rd(B2, `MFT_OFF_ICTRL);
    chk("flags two", 32'h2, 32'(rdat[7:4]));
    wr(B2, `MFT_OFF_ICTRL, 32'h2);
    wait_obs("irq two a", 2, 1'b1);
    chk("irq two b", 32'h0, 32'(obs[3]));
    chk("irq one a", 32'h0, 32'(obs[0]));
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    s_regs();
    s_hold();
    s_mode1();
    s_mode2();
    s_mode3();
    s_mode4();
    give_verdict();
  end
endmodule // tb_mft_timer
`default_nettype wire
